/* File: shared/secp_pkg.sv */
// Shared constants and types of the serial EEPROM command port.
package secp_pkg;

    // Array shape: 64 words of 16 bits, seen as 128 bytes in byte mode.
    localparam int unsigned WORDS      = 64;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned IDX_W      = 6;
    localparam int unsigned HDR_W      = 9;
    localparam int unsigned CNT_W      = 5;

    // Instruction lengths after the start bit, for word and byte mode.
    localparam logic [4:0]  HDR_LEN16  = 5'h08;
    localparam logic [4:0]  HDR_LEN8   = 5'h09;

    // Opcodes and the sub-codes carried in the top address bits.
    localparam logic [1:0]  OP_SPECIAL = 2'h0;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  OP_ERASE   = 2'h3;
    localparam logic [1:0]  SUB_WDIS   = 2'h0;
    localparam logic [1:0]  SUB_WRALL  = 2'h1;
    localparam logic [1:0]  SUB_ERALL  = 2'h2;
    localparam logic [1:0]  SUB_WEN    = 2'h3;

    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Self-timed program or erase cycle, longest time, rounded down.
    localparam int unsigned CLK_PERIOD_PS       = 4000;
    localparam int unsigned PROGRAM_CYCLE_TIME_MS = 5;
    localparam int unsigned PROGRAM_CYCLES =
        PROGRAM_CYCLE_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int unsigned TIMER_W     = 21;

    // Register map on the AHB-Lite slave.
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam int unsigned CTRL_LOCK_BIT  = 0;
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_WEN_BIT   = 1;
    localparam int unsigned STAT_ORG16_BIT = 2;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SHIFT   = 3'b001,
        ST_DESEL   = 3'b011,
        ST_BUSY    = 3'b010,
        ST_READ    = 3'b101
    } secp_state_t;

    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_WRITE     = 3'h1,
        CMD_ERASE     = 3'h2,
        CMD_ERASE_ALL = 3'h3,
        CMD_WRITE_ALL = 3'h4
    } secp_cmd_t;

endpackage

/* File: src/secp_ahb_regs.sv */
// AHB-Lite slave holding the control and status registers of the port.
module secp_ahb_regs
    import secp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             write_lock,
    input  wire logic [2:0]  status_bits
);

    logic [31:0] ctrl_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] hrdata_r;

    // Writes are served for whole-word size only, reads for any size; every answer is zero-wait OKAY.
    wire         addr_phase = hsel & hready & htrans[1];
    wire         size_ok    = (hsize == 3'h2);
    wire  [7:0]  offset     = haddr[7:0];
    wire         hit_ctrl   = (haddr[31:8] == 24'h0) & (offset == REG_CTRL);
    wire         hit_stat   = (haddr[31:8] == 24'h0) & (offset == REG_STATUS);
    wire  [31:0] rd_mux     = hit_ctrl ? ctrl_r
                            : hit_stat ? {29'h0, status_bits}
                            : 32'h0000_0000;
    wire         wr_ctrl    = wr_pend_r & (wr_addr_r == REG_CTRL);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r    <= CTRL_RESET;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= addr_phase & hwrite & size_ok & (haddr[31:8] == 24'h0);
            wr_addr_r <= offset;
            if (addr_phase && !hwrite)
                hrdata_r <= rd_mux;
            if (wr_ctrl)
                ctrl_r <= {31'h0, hwdata[CTRL_LOCK_BIT]};
        end
    end

    assign hrdata     = hrdata_r;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign write_lock = ctrl_r[CTRL_LOCK_BIT];

endmodule

/* File: src/secp_core.sv */
// Serial command port of a 1 kbit EEPROM with its array, timer and register slave.
module secp_core
    import secp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROGRAM_CYCLES
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        chip_select,
    input  wire logic        serial_clock_in,
    input  wire logic        serial_data_in,
    input  wire logic        word_width_select,
    output logic             serial_data_out,
    output logic             serial_data_out_oe
);

    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TIMER_W))
        $error("PROG_CYCLES must lie between 1 and the timer range");

    // Pin synchronisers: index 0 select, 1 clock, 2 data, 3 organization.
    logic [3:0]  sync_q1_r;
    logic [3:0]  sync_q2_r;
    logic        sck_d_r;

    for (genvar g = 0; g < 4; g++)
    begin : g_sync
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                sync_q1_r[g] <= 1'b0;
                sync_q2_r[g] <= 1'b0;
            end
            else
            begin
                sync_q1_r[g] <= g == 0 ? chip_select
                              : g == 1 ? serial_clock_in
                              : g == 2 ? serial_data_in
                              : word_width_select;
                sync_q2_r[g] <= sync_q1_r[g];
            end
        end
    end

    wire         sel_s    = sync_q2_r[0];
    wire         din_s    = sync_q2_r[2];
    wire         org_s    = sync_q2_r[3];
    wire         sck_rise = sync_q2_r[1] & ~sck_d_r;

    // Word index of an address; byte mode drops bit 0, which selects the lane.
    function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a,
                                                    input logic             o16);
        word_index = o16 ? a[IDX_W-1:0] : a[ADDR_W-1:1];
    endfunction

    secp_state_t              state_r, state_nxt;
    secp_cmd_t                cmd_r, cmd_nxt;
    logic [CNT_W-1:0]         cnt_r, cnt_nxt;
    logic [HDR_W-1:0]         hdr_r, hdr_nxt;
    logic [WORD_W-1:0]        dat_r, dat_nxt;
    logic [ADDR_W-1:0]        addr_r, addr_nxt;
    logic [WORD_W-1:0]        rd_r, rd_nxt;
    logic [TIMER_W-1:0]       timer_r, timer_nxt;
    logic                     org16_r, org16_nxt;
    logic                     wen_r, wen_nxt;
    logic                     pend_r, pend_nxt;
    logic                     status_r, status_nxt;
    logic                     dout_r, dout_nxt;
    logic                     pin_do_r, pin_oe_r;
    logic                     mem_go;
    logic [WORD_W-1:0]        mem_r [WORDS];
    logic                     write_lock;

    // Header decode on the bit being sampled now.
    wire  [HDR_W-1:0]  hdr_shift = {hdr_r[HDR_W-2:0], din_s};
    wire  [4:0]        hdr_len   = org16_r ? HDR_LEN16 : HDR_LEN8;
    wire  [4:0]        data_len  = org16_r ? 5'(WORD_W) : 5'(BYTE_W);
    wire  [4:0]        total_len = 5'(hdr_len + data_len);
    wire  [1:0]        hdr_op    = org16_r ? hdr_shift[7:6] : hdr_shift[8:7];
    wire  [ADDR_W-1:0] hdr_addr  = org16_r ? {1'b0, hdr_shift[5:0]} : hdr_shift[6:0];
    wire  [1:0]        hdr_sub   = org16_r ? hdr_shift[5:4] : hdr_shift[6:5];
    wire               hdr_end   = (cnt_r == 5'(hdr_len - 5'h01));
    wire               data_end  = (cnt_r == 5'(total_len - 5'h01));
    wire               may_write = wen_r & ~write_lock;

    // Word read for a read instruction; byte mode puts the byte in the top half.
    wire  [WORD_W-1:0] rd_word   = mem_r[word_index(hdr_addr, org16_r)];
    wire  [BYTE_W-1:0] rd_byte   = hdr_addr[0] ? rd_word[7:0] : rd_word[15:8];
    wire  [WORD_W-1:0] rd_load   = org16_r ? rd_word : {rd_byte, 8'h00};

    always_comb
    begin
        state_nxt = state_r;
        cmd_nxt   = cmd_r;
        cnt_nxt   = cnt_r;
        hdr_nxt   = hdr_r;
        dat_nxt   = dat_r;
        addr_nxt  = addr_r;
        rd_nxt    = rd_r;
        timer_nxt = timer_r;
        org16_nxt = org16_r;
        wen_nxt   = wen_r;
        pend_nxt  = pend_r;
        dout_nxt  = dout_r;
        mem_go    = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (sel_s && !status_r && sck_rise && din_s)
                begin
                    state_nxt = ST_SHIFT;
                    cnt_nxt   = '0;
                    hdr_nxt   = '0;
                    dat_nxt   = '0;
                    org16_nxt = org_s;
                end
            end
            ST_SHIFT:
            begin
                if (!sel_s)
                    state_nxt = ST_IDLE;
                else if (sck_rise)
                begin
                    cnt_nxt = 5'(cnt_r + 5'h01);
                    if (cnt_r < hdr_len)
                        hdr_nxt = hdr_shift;
                    else
                        dat_nxt = {dat_r[WORD_W-2:0], din_s};
                    if (hdr_end)
                    begin
                        addr_nxt = hdr_addr;
                        pend_nxt = may_write;
                        case (hdr_op)
                            OP_READ:
                            begin
                                state_nxt = ST_READ;
                                rd_nxt    = rd_load;
                                dout_nxt  = 1'b0;
                            end
                            OP_WRITE:
                                cmd_nxt = CMD_WRITE;
                            OP_ERASE:
                            begin
                                cmd_nxt   = CMD_ERASE;
                                state_nxt = ST_DESEL;
                            end
                            default:
                            begin
                                case (hdr_sub)
                                    SUB_WEN:
                                    begin
                                        wen_nxt   = 1'b1;
                                        cmd_nxt   = CMD_NONE;
                                        state_nxt = ST_DESEL;
                                    end
                                    SUB_WDIS:
                                    begin
                                        wen_nxt   = 1'b0;
                                        cmd_nxt   = CMD_NONE;
                                        state_nxt = ST_DESEL;
                                    end
                                    SUB_ERALL:
                                    begin
                                        cmd_nxt   = CMD_ERASE_ALL;
                                        state_nxt = ST_DESEL;
                                    end
                                    default:
                                        cmd_nxt = CMD_WRITE_ALL;
                                endcase
                            end
                        endcase
                    end
                    else if (data_end)
                        state_nxt = ST_DESEL;
                end
            end
            ST_READ:
            begin
                if (!sel_s)
                    state_nxt = ST_IDLE;
                else if (sck_rise)
                begin
                    dout_nxt = rd_r[WORD_W-1];
                    rd_nxt   = {rd_r[WORD_W-2:0], 1'b0};
                end
            end
            ST_DESEL:
            begin
                if (!sel_s)
                begin
                    if (pend_r && cmd_r != CMD_NONE)
                    begin
                        state_nxt = ST_BUSY;
                        timer_nxt = TIMER_W'(PROG_CYCLES - 1);
                        mem_go    = 1'b1;
                    end
                    else
                        state_nxt = ST_IDLE;
                end
            end
            ST_BUSY:
            begin
                if (timer_r == '0)
                    state_nxt = ST_IDLE;
                else
                    timer_nxt = timer_r - 1'b1;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Status shows while selected during a cycle and holds after it while still selected; a dummy one ends it when ready.
    always_comb
    begin
        status_nxt = sel_s
                   && (state_r == ST_BUSY
                       || (status_r && !(sck_rise && din_s)));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sck_d_r  <= 1'b0;
            state_r  <= ST_IDLE;
            cmd_r    <= CMD_NONE;
            cnt_r    <= '0;
            hdr_r    <= '0;
            dat_r    <= '0;
            addr_r   <= '0;
            rd_r     <= '0;
            timer_r  <= '0;
            org16_r  <= 1'b1;
            wen_r    <= 1'b0;
            pend_r   <= 1'b0;
            status_r <= 1'b0;
            dout_r   <= 1'b0;
            pin_do_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end
        else
        begin
            sck_d_r  <= sync_q2_r[1];
            state_r  <= state_nxt;
            cmd_r    <= cmd_nxt;
            cnt_r    <= cnt_nxt;
            hdr_r    <= hdr_nxt;
            dat_r    <= dat_nxt;
            addr_r   <= addr_nxt;
            rd_r     <= rd_nxt;
            timer_r  <= timer_nxt;
            org16_r  <= org16_nxt;
            wen_r    <= wen_nxt;
            pend_r   <= pend_nxt;
            status_r <= status_nxt;
            dout_r   <= dout_nxt;
            pin_oe_r <= status_nxt | (state_nxt == ST_READ);
            pin_do_r <= status_nxt ? (state_nxt != ST_BUSY) : dout_nxt;
        end
    end

    // Array update, done at the start of the self-timed cycle; the timer models its length.
    wire               op_all   = (cmd_r == CMD_ERASE_ALL) | (cmd_r == CMD_WRITE_ALL);
    wire               op_erase = (cmd_r == CMD_ERASE) | (cmd_r == CMD_ERASE_ALL);
    wire  [IDX_W-1:0]  wr_idx   = word_index(addr_r, org16_r);
    wire  [WORD_W-1:0] wr_src   = op_erase ? ERASED_WORD
                                : org16_r  ? dat_r
                                : {dat_r[7:0], dat_r[7:0]};

    for (genvar w = 0; w < WORDS; w++)
    begin : g_mem
        wire              hit = mem_go & (op_all | (wr_idx == IDX_W'(w)));
        wire [WORD_W-1:0] cur = mem_r[w];
        wire [WORD_W-1:0] upd = (org16_r || op_all) ? wr_src
                              : addr_r[0] ? {cur[15:8], wr_src[7:0]}
                              : {wr_src[15:8], cur[7:0]};
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                mem_r[w] <= ERASED_WORD;
            else if (hit)
                mem_r[w] <= upd;
        end
    end

    secp_ahb_regs u_regs
    (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hready      (hready),
        .hwdata      (hwdata),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .write_lock  (write_lock),
        .status_bits ({org16_r, wen_r, state_r == ST_BUSY})
    );

    assign serial_data_out    = pin_do_r;
    assign serial_data_out_oe = pin_oe_r;

endmodule

/* File: verification/secp_checker.sv */
// Concurrent checks on the ports of the serial EEPROM command port.
module secp_checker
    import secp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROGRAM_CYCLES
)
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        chip_select,
    input wire logic        serial_clock_in,
    input wire logic        serial_data_out,
    input wire logic        serial_data_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire rd_req = hsel && hready && htrans[1] && !hwrite;

    a_zero_wait: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
    a_unmapped_zero: assert property (rd_req && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_spare: assert property (rd_req && haddr == {24'h0, REG_STATUS}
        |=> hrdata[31:3] == 29'h0) else $error("status spare bits set");
    a_idle_release: assert property (!chip_select [*6] |-> !serial_data_out_oe)
        else $error("output driven while deselected");
    a_oe_needs_sel: assert property ($rose(serial_data_out_oe) |-> $past(chip_select, 3))
        else $error("output enabled without select");
    a_first_low: assert property ($rose(serial_data_out_oe) |-> !serial_data_out)
        else $error("first driven bit not low");
    a_out_on_edge: assert property ($fell(serial_data_out) && serial_data_out_oe
        && $past(serial_data_out_oe) |-> $past(serial_clock_in, 3))
        else $error("output fell without serial clock");
endmodule

bind secp_core secp_checker #(.PROG_CYCLES(PROG_CYCLES)) i_secp_checker (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .chip_select,
    .serial_clock_in, .serial_data_out, .serial_data_out_oe);

/* File: verification/secp_host_model.sv */
// Host controller model that drives the serial pins of the port.
module secp_host_model
    import secp_pkg::*;
#(
    parameter int unsigned HALF  = 8,
    parameter int unsigned GAP   = 64,
    parameter int unsigned PWRUP = 16
)
(
    input  wire logic hclk,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe,
    output logic      chip_select,
    output logic      serial_clock_in,
    output logic      serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        chip_select     = 1'b0;
        serial_clock_in = 1'b0;
        serial_data_in  = 1'b0;
    end

    task automatic power_up();
        repeat (PWRUP) @(posedge hclk);
    endtask

    task automatic raise_select();
        @(posedge hclk);
        chip_select <= 1'b1;
    endtask

    // Shifts n bits MSB first; the output level is taken at the end of each high phase.
    task automatic shift(input int n, input logic [31:0] bits, output logic [31:0] seen);
        seen = '0;
        raise_select();
        for (int i = n - 1; i >= 0; i--)
        begin
            repeat (HALF) @(posedge hclk);
            serial_data_in <= bits[i];
            repeat (HALF) @(posedge hclk);
            serial_clock_in <= 1'b1;
            repeat (HALF) @(posedge hclk);
            seen[i] = serial_data_out_oe ? serial_data_out : 1'bz;
            serial_clock_in <= 1'b0;
        end
    endtask

    task automatic deselect();
        @(posedge hclk);
        chip_select    <= 1'b0;
        serial_data_in <= 1'b0;
        repeat (GAP) @(posedge hclk);
    endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the serial EEPROM command port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import secp_pkg::*;

    localparam int unsigned PROG = 200;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        word_width_select;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic        chip_select;
    logic        serial_clock_in;
    logic        serial_data_in;
    logic        serial_data_out;
    logic        serial_data_out_oe;
    wire         hready = hreadyout;
    int          n_errors;
    int          n_compared;

    secp_core #(.PROG_CYCLES(PROG)) i_secp_core (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .chip_select,
        .serial_clock_in, .serial_data_in, .word_width_select, .serial_data_out,
        .serial_data_out_oe);

    secp_host_model i_secp_host_model (.hclk, .serial_data_out, .serial_data_out_oe,
        .chip_select, .serial_clock_in, .serial_data_in);

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic finish_test();
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    task automatic wait_ready();
        for (int k = 0; k <= 50; k++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        n_errors++;
        finish_test();
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic reg_rd(input logic [31:0] a, exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        chk("hrdata", exp, rd);
    endtask

    task automatic cmd(input int n, input logic [31:0] bits);
        logic [31:0] seen;
        i_secp_host_model.shift(n, bits, seen);
        i_secp_host_model.deselect();
    endtask

    task automatic rd_word(input logic [5:0] a, input logic [15:0] e);
        logic [31:0] seen;
        i_secp_host_model.shift(25, {1'b1, OP_READ, a, 16'h0}, seen);
        i_secp_host_model.deselect();
        chk("read_word", {16'h0, e}, {15'h0, seen[16:0]});
    endtask

    // Starts a self-timed cycle, polls busy then ready, then releases the output.
    task automatic prog(input int n, input logic [31:0] bits);
        logic [31:0] seen;
        cmd(n, bits);
        i_secp_host_model.raise_select();
        repeat (8) @(posedge hclk);
        chk("busy_out", 32'h2, {30'h0, serial_data_out_oe, serial_data_out});
        reg_rd({24'h0, REG_STATUS}, {29'h0, word_width_select, 2'h3});
        i_secp_host_model.shift(1, 32'h1, seen);
        chk("busy_held", 32'h2, {30'h0, serial_data_out_oe, serial_data_out});
        repeat (PROG) @(posedge hclk);
        chk("ready_out", 32'h3, {30'h0, serial_data_out_oe, serial_data_out});
        i_secp_host_model.shift(1, 32'h1, seen);
        repeat (8) @(posedge hclk);
        chk("released_oe", 32'h0, {31'h0, serial_data_out_oe});
        i_secp_host_model.deselect();
    endtask

    initial
    begin
        logic [31:0] rd;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        word_width_select = 1'b1;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        n_errors = 0;
        n_compared = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        i_secp_host_model.power_up();
        reg_rd({24'h0, REG_STATUS}, 32'h4);
        reg_rd(32'h100, 32'h0);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h1, rd);
        reg_rd({24'h0, REG_CTRL}, 32'h1);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h0, rd);
        cmd(25, {1'b1, OP_WRITE, 6'h05, 16'h1234});
        rd_word(6'h05, ERASED_WORD);
        cmd(9, {1'b1, OP_SPECIAL, SUB_WEN, 4'h0});
        reg_rd({24'h0, REG_STATUS}, 32'h6);
        prog(25, {1'b1, OP_WRITE, 6'h05, 16'hA5C3});
        rd_word(6'h05, 16'hA5C3);
        prog(25, {1'b1, OP_WRITE, 6'h05, 16'h1234});
        rd_word(6'h05, 16'h1234);
        prog(9, {1'b1, OP_ERASE, 6'h05});
        rd_word(6'h05, ERASED_WORD);
        prog(25, {1'b1, OP_SPECIAL, SUB_WRALL, 4'h0, 16'h5A0F});
        rd_word(6'h00, 16'h5A0F);
        rd_word(6'h3F, 16'h5A0F);
        cmd(5, {1'b1, OP_WRITE, 2'h0});
        reg_rd({24'h0, REG_STATUS}, 32'h6);
        prog(11, {2'b00, 1'b1, OP_SPECIAL, SUB_ERALL, 4'h0});
        rd_word(6'h11, ERASED_WORD);
        @(posedge hclk);
        word_width_select <= 1'b0;
        prog(18, {1'b1, OP_WRITE, 7'h01, 8'h3C});
        i_secp_host_model.shift(18, {1'b1, OP_READ, 7'h01, 8'h00}, rd);
        i_secp_host_model.deselect();
        chk("read_byte", 32'h0000_003C, {23'h0, rd[8:0]});
        @(posedge hclk);
        word_width_select <= 1'b1;
        rd_word(6'h00, 16'hFF3C);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h1, rd);
        cmd(25, {1'b1, OP_WRITE, 6'h00, 16'h7777});
        reg_rd({24'h0, REG_STATUS}, 32'h6);
        rd_word(6'h00, 16'hFF3C);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h0, rd);
        cmd(9, {1'b1, OP_SPECIAL, SUB_WDIS, 4'h0});
        cmd(25, {1'b1, OP_WRITE, 6'h00, 16'h4321});
        rd_word(6'h00, 16'hFF3C);
        finish_test();
    end
endmodule
